//--- pkg/relay_pkg.sv
package relay_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] cfg_off = 8'h00;
  localparam logic [7:0] alarm_thr_off = 8'h04;
  localparam logic [7:0] meas_off = 8'h08;
  localparam logic [7:0] cmd_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;

  // ----------------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------------
  localparam int cfg_failsafe_bit = 0;
  localparam int cfg_mirror_bit = 1;
  localparam int cfg_inhibit_en_bit = 2;
  localparam int cfg_ack_inhibit_bit = 3;
  localparam int cfg_relay_ack_bit = 4;
  localparam int cfg_corr_flt_bit = 5;
  localparam int cfg_test_relay_bit = 6;
  localparam logic [6:0] cfg_reset = 7'h4d;

  // ----------------------------------------------------------------------
  // Command bits (self-clearing)
  // ----------------------------------------------------------------------
  localparam int cmd_ack_bit = 0;
  localparam int cmd_test_bit = 1;
  localparam int cmd_fault_bit = 2;
  localparam int cmd_fault_clr_bit = 3;

  // ----------------------------------------------------------------------
  // Hysteresis and timing
  // ----------------------------------------------------------------------
  localparam int hyst_percent = 20;
  localparam int clk_hz = 40_000_000;
  localparam int corr_pulse_s = 3;
  localparam int corr_pulse_cycles = corr_pulse_s * clk_hz;
  localparam int test_pulse_ms = 1;
  localparam int test_pulse_cycles = test_pulse_ms * (clk_hz / 1000);
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef struct packed {
    logic insulation_alarm_relay;
    logic preventive_relay;
    logic corrected_fault;
  } relay_out_t;

endpackage : relay_pkg

//--- rtl/safety_relay_output_logic.sv
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// - Mirror mode drives preventive relay as inverse of insulation alarm relay.
// - Deficiency or supply loss de-energizes both relays to the same level.
// - In mirror mode preventive alarm shows only on indicator and status.
// - Inhibition input, when enabled, raises an alarm whenever it is active; cfg_ack_inhibit_bit is not used.
// - Inhibition input off ignores that input; monitoring continues normally.
// - Normal: inhibition open, alarm contact closed, preventive contact open.
// - Mirror mode, alarm or inhibition: alarm contact open, preventive contact closed.
// - Optional corrected-fault pulse lasts 3 s after a fault clears.
// - No relay toggling on acknowledge or self-test when those options are off.
// - Alarm off at threshold +20 percent, on at -20 percent.
module safety_relay_output_logic #(
  parameter int corr_cycles = relay_pkg::corr_pulse_cycles,
  parameter int test_cycles = relay_pkg::test_pulse_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic inhibit_pin,
  input wire logic supply_ok_pin,
  output relay_pkg::relay_out_t relays,
  output logic preventive_indicator
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] inh_sync;
  logic [1:0] sup_sync;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inh_sync <= 2'b00;
      sup_sync <= 2'b00;
    end else begin
      inh_sync <= {inh_sync[0], inhibit_pin};
      sup_sync <= {sup_sync[0], supply_ok_pin};
    end
  end
  wire logic inhibit_in = inh_sync[1];
  wire logic supply_ok = sup_sync[1];

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [6:0] cfg, next_cfg;
  logic [31:0] alarm_thr, next_alarm_thr;
  logic [31:0] meas, next_meas;
  logic product_fault, next_product_fault;
  logic ack_pulse, next_ack_pulse;
  logic test_pulse, next_test_pulse;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic aw_open, next_aw_open;
  logic w_open, next_w_open;
  logic ar_open, next_ar_open;
  logic [31:0] status_word;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] wr;
    wr = 32'h0000_0000;
    next_cfg = cfg;
    next_alarm_thr = alarm_thr;
    next_meas = meas;
    next_product_fault = product_fault;
    next_ack_pulse = 1'b0;
    next_test_pulse = 1'b0;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = relay_pkg::resp_okay;
      unique case (aw_addr)
        relay_pkg::cfg_off: begin
          wr = merge({25'h0, cfg}, w_data, w_strb);
          next_cfg = wr[6:0];
        end
        relay_pkg::alarm_thr_off: next_alarm_thr = merge(alarm_thr, w_data, w_strb);
        relay_pkg::meas_off: next_meas = merge(meas, w_data, w_strb);
        relay_pkg::cmd_off: begin
          wr = merge(32'h0000_0000, w_data, w_strb);
          next_ack_pulse = wr[relay_pkg::cmd_ack_bit];
          next_test_pulse = wr[relay_pkg::cmd_test_bit];
          if (wr[relay_pkg::cmd_fault_bit]) begin
            next_product_fault = 1'b1;
          end else if (wr[relay_pkg::cmd_fault_clr_bit]) begin
            next_product_fault = 1'b0;
          end
        end
        relay_pkg::status_off: ;
        default: next_bresp = relay_pkg::resp_slverr;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = relay_pkg::resp_okay;
      unique case (s_axi_araddr)
        relay_pkg::cfg_off: next_rdata = {25'h0, cfg};
        relay_pkg::alarm_thr_off: next_rdata = alarm_thr;
        relay_pkg::meas_off: next_rdata = meas;
        relay_pkg::cmd_off: next_rdata = 32'h0000_0000;
        relay_pkg::status_off: next_rdata = status_word;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = relay_pkg::resp_slverr;
        end
      endcase
    end
    // Ready flags are registered inverses of the next held state, so each port comes from a flip-flop.
    next_aw_open = !next_aw_held;
    next_w_open = !next_w_held;
    next_ar_open = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= relay_pkg::cfg_reset;
      alarm_thr <= 32'h0000_0000;
      meas <= 32'hffff_ffff;
      product_fault <= 1'b0;
      ack_pulse <= 1'b0;
      test_pulse <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
      aw_open <= 1'b1;
      w_open <= 1'b1;
      ar_open <= 1'b1;
    end else begin
      cfg <= next_cfg;
      alarm_thr <= next_alarm_thr;
      meas <= next_meas;
      product_fault <= next_product_fault;
      ack_pulse <= next_ack_pulse;
      test_pulse <= next_test_pulse;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      aw_open <= next_aw_open;
      w_open <= next_w_open;
      ar_open <= next_ar_open;
    end
  end

  assign s_axi_awready = aw_open;
  assign s_axi_wready = w_open;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = ar_open;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // ----------------------------------------------------------------------
  // Alarm decision and relay drive
  // ----------------------------------------------------------------------
  logic ins_alarm, next_ins_alarm;
  logic prev_alarm, next_prev_alarm;
  logic [31:0] corr_cnt, next_corr_cnt;
  logic [31:0] test_cnt, next_test_cnt;
  logic toggle, next_toggle;
  relay_pkg::relay_out_t next_relays;
  logic next_prev_ind;
  logic inhibit_active;
  logic [39:0] meas_x100;
  logic [39:0] thr_hi;
  logic [39:0] thr_lo;

  always_comb begin
    logic alarm_any;
    alarm_any = 1'b0;
    meas_x100 = {8'h00, meas} * 40'd100;
    thr_hi = {8'h00, alarm_thr} * 40'(100 + relay_pkg::hyst_percent);
    thr_lo = {8'h00, alarm_thr} * 40'(100 - relay_pkg::hyst_percent);
    next_ins_alarm = ins_alarm;
    if (meas_x100 <= thr_lo) begin
      next_ins_alarm = 1'b1;
    end else if (meas_x100 >= thr_hi) begin
      next_ins_alarm = 1'b0;
    end
    // Preventive alarm uses only the upper threshold thr_hi, without hysteresis.
    next_prev_alarm = (meas_x100 < thr_hi);
    inhibit_active = cfg[relay_pkg::cfg_inhibit_en_bit] && inhibit_in;
    next_corr_cnt = corr_cnt;
    if (ins_alarm && !next_ins_alarm && cfg[relay_pkg::cfg_corr_flt_bit]) begin
      next_corr_cnt = 32'(corr_cycles);
    end else if (!cfg[relay_pkg::cfg_corr_flt_bit]) begin
      // Turning the option off also cuts a pulse that is under way.
      next_corr_cnt = 32'h0000_0000;
    end else if (corr_cnt != 32'h0000_0000) begin
      next_corr_cnt = corr_cnt - 32'h0000_0001;
    end
    next_test_cnt = test_cnt;
    next_toggle = 1'b0;
    if ((ack_pulse && cfg[relay_pkg::cfg_relay_ack_bit]) ||
        (test_pulse && cfg[relay_pkg::cfg_test_relay_bit])) begin
      next_test_cnt = 32'(test_cycles);
    end else if (test_cnt != 32'h0000_0000) begin
      next_test_cnt = test_cnt - 32'h0000_0001;
      next_toggle = 1'b1;
    end
    alarm_any = ins_alarm || inhibit_active || toggle;
    next_relays.corrected_fault = (corr_cnt != 32'h0000_0000);
    if (!supply_ok || product_fault) begin
      next_relays.insulation_alarm_relay = 1'b0;
      next_relays.preventive_relay = 1'b0;
    end else if (cfg[relay_pkg::cfg_mirror_bit]) begin
      next_relays.insulation_alarm_relay = !alarm_any;
      next_relays.preventive_relay = alarm_any;
    end else begin
      next_relays.insulation_alarm_relay = cfg[relay_pkg::cfg_failsafe_bit] ? !alarm_any : alarm_any;
      next_relays.preventive_relay = prev_alarm || toggle;
    end
    next_prev_ind = prev_alarm;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ins_alarm <= 1'b0;
      prev_alarm <= 1'b0;
      corr_cnt <= 32'h0000_0000;
      test_cnt <= 32'h0000_0000;
      toggle <= 1'b0;
      relays <= '0;
      preventive_indicator <= 1'b0;
    end else begin
      ins_alarm <= next_ins_alarm;
      prev_alarm <= next_prev_alarm;
      corr_cnt <= next_corr_cnt;
      test_cnt <= next_test_cnt;
      toggle <= next_toggle;
      relays <= next_relays;
      preventive_indicator <= next_prev_ind;
    end
  end

  assign status_word = {26'h0, inhibit_active, product_fault, supply_ok, prev_alarm,
                        relays.preventive_relay, relays.insulation_alarm_relay};

endmodule : safety_relay_output_logic

//--- verification/plc_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Controller that reads both contacts and drives inhibition
// ----------------------------------------------------------------------
module plc_model (
  input wire logic aclk,
  input wire logic inhibit_cmd,
  input wire relay_pkg::relay_out_t relays,
  output logic inhibit_pin,
  output logic [1:0] plc_state
);
  logic ins;
  logic prev;
  assign ins = relays.insulation_alarm_relay;
  assign prev = relays.preventive_relay;
  always_ff @(posedge aclk) begin
    inhibit_pin <= inhibit_cmd;
  end
  // States: 0 normal, 1 alarm, 2 inhibited, 3 inoperative.
  always_comb begin
    if (ins == prev || (inhibit_pin && ins)) begin
      plc_state = 2'h3;
    end else if (inhibit_pin) begin
      plc_state = 2'h2;
    end else begin
      plc_state = ins ? 2'h0 : 2'h1;
    end
  end
endmodule : plc_model

//--- verification/relay_chk.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Relay and bus checker
// ----------------------------------------------------------------------
module relay_chk #(
  parameter int corr_cycles = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic inhibit_pin,
  input wire logic supply_ok_pin,
  input wire relay_pkg::relay_out_t relays
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [6:0] cfg;
  logic [6:0] next_cfg;
  logic [31:0] cf_cnt;
  logic [31:0] next_cf_cnt;
  logic wr;
  logic ins;
  logic prev;
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ins = relays.insulation_alarm_relay;
  assign prev = relays.preventive_relay;
  // Shadow of the configuration word, taken when address and data meet.
  always_comb begin
    next_cfg = cfg;
    if (wr && s_axi_awaddr == relay_pkg::cfg_off) begin
      next_cfg = s_axi_wdata[6:0];
    end
    next_cf_cnt = relays.corrected_fault ? cf_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge aclk) begin
    cfg <= aresetn ? next_cfg : relay_pkg::cfg_reset;
    cf_cnt <= aresetn ? next_cf_cnt : 32'h0;
  end
  sequence sup_lost;
    !supply_ok_pin [*4];
  endsequence
  sequence inh_held;
    (inhibit_pin && cfg[2] && cfg[0]) [*5];
  endsequence
  chk_mirror_inverse: assert property (cfg[1] && $past(cfg[1], 3) && (ins || prev) |-> ins != prev)
    else $error("relays not inverted");
  chk_relays_together: assert property (cfg[1] && $past(cfg[1], 3) && $rose(prev) |-> $fell(ins) || !$past(ins))
    else $error("preventive relay moved alone");
  chk_supply_drop: assert property (sup_lost |-> !ins && !prev)
    else $error("relays energized without supply");
  chk_inhibit_alarm: assert property (inh_held |-> !ins)
    else $error("inhibition raised no alarm");
  chk_corr_length: assert property ($fell(relays.corrected_fault) |-> cf_cnt == corr_cycles)
    else $error("corrected fault pulse length wrong");
  chk_corr_off: assert property (!cfg[5] && $stable(cfg[5]) && !$past(cfg[5], 4) |-> !relays.corrected_fault)
    else $error("corrected fault pulse while disabled");
  chk_ack_quiet: assert property (wr && s_axi_awaddr == relay_pkg::cmd_off && s_axi_wdata[1:0] != 2'h0
      && !cfg[4] && !cfg[6] |=> $stable(relays) [*4])
    else $error("relays toggled on acknowledge or test");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : relay_chk

bind safety_relay_output_logic relay_chk #(.corr_cycles(corr_cycles)) chk_inst (.*);

//--- verification/safety_relay_output_logic_test.sv
`timescale 1ns/1ps

module safety_relay_output_logic_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic supply_ok_pin = 1'b1, inhibit_cmd = 1'b0, probe = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, plc_state;
  logic [31:0] s_axi_rdata, seed = 32'h3a, thr;
  logic inhibit_pin, preventive_indicator;
  relay_pkg::relay_out_t relays;
  logic [33:0] exp_q[$];
  int err_total = 0, compares = 0, i;

  safety_relay_output_logic #(.corr_cycles(20), .test_cycles(5)) safety_relay_output_logic_inst (.*);
  plc_model plc_model_inst (.*);

  always #12.5 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift

  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    if (rd) begin
      exp_q.push_back(e);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end else begin
      exp_q.push_back(e);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = rd ? s_axi_arready : s_axi_awready;
      tw = s_axi_wready;
      tb = rd ? s_axi_rvalid : s_axi_bvalid;
      @(posedge aclk);
      if (ta && rd) s_axi_arvalid <= 1'b0;
      if (ta && !rd) s_axi_awvalid <= 1'b0;
      if (tw && !rd) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 50) begin
      err_total++;
      finish_test();
    end
  endtask : bus

  task automatic look(input int waits, input logic [5:0] e);
    repeat (waits) @(posedge aclk);
    exp_q.push_back({28'h0, e});
    probe <= 1'b1;
    @(posedge aclk);
    probe <= 1'b0;
  endtask : look

  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      check("write resp", {32'h0, s_axi_bresp}, exp_q.pop_front());
    end
    if (probe) begin
      check("relays", {28'h0, relays, preventive_indicator, plc_state}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b1, relay_pkg::cfg_off, 32'h0, 34'h4d);
    bus(1'b1, relay_pkg::meas_off, 32'h0, 34'hffffffff);
    bus(1'b1, 8'h20, 32'h0, {relay_pkg::resp_slverr, 32'h0});
    bus(1'b0, 8'h20, 32'h0, {32'h0, relay_pkg::resp_slverr});
    s_axi_wstrb <= 4'h1;
    bus(1'b0, relay_pkg::alarm_thr_off, 32'h12345678, 34'h0);
    s_axi_wstrb <= 4'hf;
    bus(1'b1, relay_pkg::alarm_thr_off, 32'h0, 34'h78);
    bus(1'b0, relay_pkg::cfg_off, 32'h0f, 34'h0);
    look(4, 6'h20);
    bus(1'b1, relay_pkg::status_off, 32'h0, 34'h09);
    for (i = 0; i < 2; i++) begin
      seed = xorshift(seed);
      thr = 32'h5 * (32'h14 + seed % 32'hc8);
      bus(1'b0, relay_pkg::meas_off, 32'hffffffff, 34'h0);
      bus(1'b0, relay_pkg::alarm_thr_off, thr, 34'h0);
      bus(1'b0, relay_pkg::meas_off, thr, 34'h0);
      look(3, 6'h24);
      bus(1'b0, relay_pkg::meas_off, thr * 4 / 5, 34'h0);
      look(3, 6'h15);
      bus(1'b0, relay_pkg::meas_off, thr, 34'h0);
      look(3, 6'h15);
      bus(1'b0, relay_pkg::meas_off, thr * 6 / 5, 34'h0);
      look(3, 6'h20);
    end
    bus(1'b0, relay_pkg::cmd_off, 32'h3, 34'h0);
    look(3, 6'h20);
    bus(1'b0, relay_pkg::cfg_off, 32'h4f, 34'h0);
    bus(1'b0, relay_pkg::cmd_off, 32'h2, 34'h0);
    look(2, 6'h11);
    look(8, 6'h20);
    bus(1'b0, relay_pkg::cmd_off, 32'h4, 34'h0);
    look(3, 6'h03);
    bus(1'b0, relay_pkg::cmd_off, 32'h8, 34'h0);
    look(3, 6'h20);
    supply_ok_pin <= 1'b0;
    look(6, 6'h03);
    supply_ok_pin <= 1'b1;
    look(6, 6'h20);
    inhibit_cmd <= 1'b1;
    look(8, 6'h12);
    inhibit_cmd <= 1'b0;
    bus(1'b0, relay_pkg::cfg_off, 32'h0b, 34'h0);
    inhibit_cmd <= 1'b1;
    look(8, 6'h23);
    inhibit_cmd <= 1'b0;
    bus(1'b0, relay_pkg::cfg_off, 32'h2f, 34'h0);
    bus(1'b0, relay_pkg::meas_off, 32'h0, 34'h0);
    look(3, 6'h15);
    bus(1'b0, relay_pkg::meas_off, 32'hffffffff, 34'h0);
    look(2, 6'h28);
    look(30, 6'h20);
    bus(1'b0, relay_pkg::cfg_off, 32'h0f, 34'h0);
    finish_test();
  end
endmodule : safety_relay_output_logic_test
